// *** src/bulk_ptr_defs.svh ***
// register offsets, field positions and reset values of the bulk and done-list pointers
`ifndef BULK_PTR_DEFS_SVH
`define BULK_PTR_DEFS_SVH

`define ADDR_BULK_HEAD 32'h3000_2C28
`define ADDR_BULK_CURRENT 32'h3000_2C2C
`define ADDR_DONE_HEAD 32'h3000_2C30
`define ADDR_BULK_CTRL 32'h3000_2C80
`define ADDR_IRQ_STATUS 32'h3000_2C84
`define ADDR_IRQ_ENABLE 32'h3000_2C88
`define ADDR_IRQ_CLEAR 32'h3000_2C8C
`define PTR_RESET 28'h0000000
`define PTR_LSB 4
`define PTR_W 28
`define CTRL_ENABLE_BIT 0
`define CTRL_FILLED_BIT 1
`define IRQ_WRITEBACK_BIT 0
`define IRQ_INIT_DONE_BIT 1
`define IRQ_W 2

`endif

// *** src/bulk_ptr_pkg.sv ***
// types shared by the bulk and done-list pointer block
package bulk_ptr_pkg;
  typedef logic [27:0] ptr_t;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LINK = 2'b01,
    ST_SWAP = 2'b10
  } done_state_t;
endpackage : bulk_ptr_pkg

// *** src/usb_host_bulk_done_list_pointers.sv ***
// bulk head, bulk current and completed-queue head pointers with register port
// Behaviour
// - bulk traversal starts at the head pointer, bits 31..4, software read and write.
// - during initialization the head pointer is loaded from the communication area.
// - after serving a descriptor the current pointer advances to the next one.
// - a new frame resumes from the current pointer, not from the head.
// - at list end, if filled flag set copy head to current and clear flag.
// - current pointer resets to zero; zero means end of list.
// - descriptors are served round-robin in insertion order.
// - on completion the done-head is written into the descriptor's next link; a completion outside ST_IDLE or together with a write-back is dropped.
// - writing done-head to the communication area clears it to zero; a write-back outside ST_IDLE is ignored.
// - that write-back also sets the completed write-back interrupt flag.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "bulk_ptr_defs.svh"

module usb_host_bulk_done_list_pointers
  import bulk_ptr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // list engine
  input wire logic init_load_i,
  input wire logic [31:0] init_bulk_head_i,
  input wire logic frame_start_i,
  input wire logic ed_done_i,
  input wire logic [31:0] ed_next_i,
  input wire logic list_filled_set_i,
  input wire logic td_done_i,
  input wire logic [31:0] td_addr_i,
  input wire logic done_writeback_i,
  output logic [31:0] bulk_current_o,
  output logic [31:0] bulk_head_o,
  output logic bulk_enable_o,
  output logic bulk_active_o,
  output logic link_wr_o,
  output logic [31:0] link_addr_o,
  output logic [31:0] link_data_o,
  output logic [31:0] done_head_o,
  output logic irq_o
);

  // ****************************************
  // register state
  // ****************************************
  ptr_t head_q;
  ptr_t current_q;
  ptr_t done_q;
  logic enable_q;
  logic filled_q;
  logic [`IRQ_W-1:0] irq_status_q;
  logic [`IRQ_W-1:0] irq_enable_q;
  done_state_t state_q;
  ptr_t td_q;
  logic link_wr_q;
  logic [31:0] link_addr_q;
  logic [31:0] link_data_q;
  logic active_q;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [31:0] widen(input ptr_t p);
    widen = {p, 4'h0};
  endfunction : widen

  wire wr_head = reg_wr_i && hit(reg_addr_i, `ADDR_BULK_HEAD);
  wire wr_current = reg_wr_i && hit(reg_addr_i, `ADDR_BULK_CURRENT);
  wire wr_ctrl = reg_wr_i && hit(reg_addr_i, `ADDR_BULK_CTRL);
  wire at_end = (current_q == `PTR_RESET);

  // ****************************************
  // bulk head pointer
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      head_q <= `PTR_RESET;
    else if (init_load_i)
      head_q <= init_bulk_head_i[31:`PTR_LSB];
    else if (wr_head)
      head_q <= reg_wdata_i[31:`PTR_LSB];
  end

  // ****************************************
  // bulk current pointer
  // ****************************************
  // the pointer is never rewound on frame_start_i, so a frame resumes where the last one stopped
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      current_q <= `PTR_RESET;
    else if (wr_current && !enable_q)
      current_q <= reg_wdata_i[31:`PTR_LSB];
    else if (enable_q && at_end && filled_q)
      current_q <= head_q;
    else if (enable_q && ed_done_i && !at_end)
      current_q <= ed_next_i[31:`PTR_LSB];
  end

  // writes to the current pointer while enabled are dropped; reads stay live
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      active_q <= 1'b0;
    else
      active_q <= enable_q && !at_end && (active_q || frame_start_i);
  end

  // ****************************************
  // control: enable and list-filled flag
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      enable_q <= 1'b0;
    else if (wr_ctrl)
      enable_q <= reg_wdata_i[`CTRL_ENABLE_BIT];
  end

  // a set from the engine or software wins over the end-of-list clear
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      filled_q <= 1'b0;
    else if (list_filled_set_i || (wr_ctrl && reg_wdata_i[`CTRL_FILLED_BIT]))
      filled_q <= 1'b1;
    else if (enable_q && at_end && filled_q)
      filled_q <= 1'b0;
  end

  // ****************************************
  // completed queue
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      td_q <= `PTR_RESET;
      done_q <= `PTR_RESET;
      link_wr_q <= 1'b0;
      link_addr_q <= 32'h0000_0000;
      link_data_q <= 32'h0000_0000;
    end
    else
    begin
      link_wr_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (done_writeback_i)
            done_q <= `PTR_RESET;
          else if (td_done_i)
          begin
            td_q <= td_addr_i[31:`PTR_LSB];
            state_q <= ST_LINK;
          end
        end
        ST_LINK:
        begin
          link_wr_q <= 1'b1;
          link_addr_q <= widen(td_q);
          link_data_q <= widen(done_q);
          state_q <= ST_SWAP;
        end
        ST_SWAP:
        begin
          done_q <= td_q;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [`IRQ_W-1:0] irq_event;
  logic [`IRQ_W-1:0] irq_clear;
  always_comb
  begin
    irq_event = '0;
    irq_event[`IRQ_WRITEBACK_BIT] = done_writeback_i && (state_q == ST_IDLE);
    irq_event[`IRQ_INIT_DONE_BIT] = init_load_i;
    irq_clear = '0;
    if (reg_wr_i && hit(reg_addr_i, `ADDR_IRQ_CLEAR))
      irq_clear = reg_wdata_i[`IRQ_W-1:0];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_status_q <= '0;
    else
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_enable_q <= '0;
    else if (reg_wr_i && hit(reg_addr_i, `ADDR_IRQ_ENABLE))
      irq_enable_q <= reg_wdata_i[`IRQ_W-1:0];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(((irq_status_q & ~irq_clear) | irq_event) & irq_enable_q);
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (!reg_rd_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (hit(reg_addr_i, `ADDR_BULK_HEAD))
      reg_rdata_o <= widen(head_q);
    else if (hit(reg_addr_i, `ADDR_BULK_CURRENT))
      reg_rdata_o <= widen(current_q);
    else if (hit(reg_addr_i, `ADDR_DONE_HEAD))
      reg_rdata_o <= widen(done_q);
    else if (hit(reg_addr_i, `ADDR_BULK_CTRL))
      reg_rdata_o <= {30'h0, filled_q, enable_q};
    else if (hit(reg_addr_i, `ADDR_IRQ_STATUS))
      reg_rdata_o <= {30'h0, irq_status_q};
    else if (hit(reg_addr_i, `ADDR_IRQ_ENABLE))
      reg_rdata_o <= {30'h0, irq_enable_q};
    else
      reg_rdata_o <= 32'h0000_0000;
  end

  // ****************************************
  // engine-facing outputs
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bulk_current_o <= 32'h0000_0000;
      bulk_head_o <= 32'h0000_0000;
      bulk_enable_o <= 1'b0;
      done_head_o <= 32'h0000_0000;
    end
    else
    begin
      bulk_current_o <= widen(current_q);
      bulk_head_o <= widen(head_q);
      bulk_enable_o <= enable_q;
      done_head_o <= widen(done_q);
    end
  end

  assign bulk_active_o = active_q;
  assign link_wr_o = link_wr_q;
  assign link_addr_o = link_addr_q;
  assign link_data_o = link_data_q;

endmodule : usb_host_bulk_done_list_pointers

// *** tb/desc_mem_model.sv ***
// memory side of the list engine: endpoint chain and completion links
`timescale 1ns/1ps
module desc_mem_model (
  input wire logic core_clk_i,
  input wire logic wr_i,
  input wire logic [31:0] wa_i,
  input wire logic [31:0] wd_i,
  input wire logic [31:0] cur_i,
  output logic [31:0] next_o
);
  logic [31:0] mem_q [16];
  // unwritten words hold a pattern, so a missed link write never reads as zero
  initial
    for (int i = 0; i < 16; i++)
      mem_q[i] = 32'hDEAD_BEE0 + i;
  always @(posedge core_clk_i)
    if (wr_i)
      mem_q[wa_i[11:8]] <= wd_i;
  // chain in insertion order; past the tail reads as end of list
  always_comb
    case (cur_i)
      32'h0000_0200: next_o = 32'h0000_0210;
      32'h0000_0210: next_o = 32'h0000_0220;
      default: next_o = 32'h0000_0000;
    endcase
endmodule : desc_mem_model

// *** tb/ptr_asserts.sv ***
// port assertions for the bulk and done-list pointer block
`timescale 1ns/1ps
module ptr_asserts (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic init_load_i,
  input wire logic [31:0] init_bulk_head_i,
  input wire logic ed_done_i,
  input wire logic [31:0] ed_next_i,
  input wire logic td_done_i,
  input wire logic [31:0] td_addr_i,
  input wire logic done_writeback_i,
  input wire logic [31:0] bulk_current_o,
  input wire logic [31:0] bulk_head_o,
  input wire logic link_wr_o,
  input wire logic [31:0] link_addr_o,
  input wire logic [31:0] link_data_o,
  input wire logic [31:0] done_head_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ****************
  // completion steps
  // ****************
  sequence s_swap;
    ##2 done_head_o == $past(link_addr_o, 2);
  endsequence
  sequence s_clr;
    ##2 done_head_o == 32'h0;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_ptr_nibble: assert property ((bulk_current_o[3:0] | bulk_head_o[3:0] | done_head_o[3:0])
    == 4'h0) else $error("pointer low nibble not zero");
  a_link_addr: assert property (link_wr_o |-> $past(td_done_i, 2) &&
    link_addr_o[31:4] == $past(td_addr_i[31:4], 2)) else $error("link write without completion");
  a_link_data: assert property (link_wr_o |-> link_data_o == done_head_o)
    else $error("link data is not the old done head");
  a_done_swap: assert property (link_wr_o |-> s_swap)
    else $error("done head not replaced by descriptor");
  a_wb_clear: assert property (done_writeback_i |-> s_clr)
    else $error("done head not cleared by write-back");
  a_ed_advance: assert property (ed_done_i |->
    ##2 bulk_current_o[31:4] == $past(ed_next_i[31:4], 2)) else $error("current did not advance");
  a_head_load: assert property (init_load_i |->
    ##2 bulk_head_o[31:4] == $past(init_bulk_head_i[31:4], 2)) else $error("head not loaded");
endmodule : ptr_asserts
bind usb_host_bulk_done_list_pointers ptr_asserts chk_u (.core_clk_i, .resetn_i, .reg_rd_i,
  .reg_rdata_o, .init_load_i, .init_bulk_head_i, .ed_done_i, .ed_next_i, .td_done_i,
  .td_addr_i, .done_writeback_i, .bulk_current_o, .bulk_head_o, .link_wr_o, .link_addr_o,
  .link_data_o, .done_head_o);

// *** tb/usb_host_bulk_done_list_pointers_tb.sv ***
// testbench for the bulk and done-list pointer block
`timescale 1ns/1ps
`include "bulk_ptr_defs.svh"
module usb_host_bulk_done_list_pointers_tb;
  logic core_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, init_load_i = 0;
  logic frame_start_i = 0, ed_done_i = 0, list_filled_set_i = 0, td_done_i = 0;
  logic done_writeback_i = 0, bulk_enable_o, bulk_active_o, link_wr_o, irq_o;
  logic [31:0] reg_addr_i = 0, reg_wdata_i = 0, init_bulk_head_i = 0, td_addr_i = 0;
  logic [31:0] ed_next_i, reg_rdata_o, bulk_current_o, bulk_head_o, link_addr_o;
  logic [31:0] link_data_o, done_head_o;
  int fail_count = 0;
  int tests_run = 0;
  always #5 core_clk_i = ~core_clk_i;
  usb_host_bulk_done_list_pointers dut_u (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .init_load_i, .init_bulk_head_i, .frame_start_i,
    .ed_done_i, .ed_next_i, .list_filled_set_i, .td_done_i, .td_addr_i, .done_writeback_i,
    .bulk_current_o, .bulk_head_o, .bulk_enable_o, .bulk_active_o, .link_wr_o, .link_addr_o,
    .link_data_o, .done_head_o, .irq_o);
  desc_mem_model mem_u (.core_clk_i, .wr_i(link_wr_o), .wa_i(link_addr_o),
    .wd_i(link_data_o), .cur_i(bulk_current_o), .next_o(ed_next_i));
  // *****
  // tasks
  // *****
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge core_clk_i) reg_wr_i <= 1'h0;
    cyc(1);
  endtask : w
  task automatic r(input string n, input logic [31:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge core_clk_i) reg_rd_i <= 1'h0;
    #1 chk(n, reg_rdata_o, e);
    cyc(1);
  endtask : r
  task automatic td(input logic [31:0] a);
    td_done_i <= 1'h1;
    td_addr_i <= a;
    @(posedge core_clk_i) td_done_i <= 1'h0;
    cyc(4);
  endtask : td
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // *********
  // sequence
  // *********
  initial
  begin
    cyc(16);
    resetn_i <= 1'h1;
    cyc(1);
    r("cur", `ADDR_BULK_CURRENT, 32'h0);
    init_bulk_head_i <= 32'h0000_0AB7;
    init_load_i <= 1'h1;
    @(posedge core_clk_i) init_load_i <= 1'h0;
    cyc(1);
    r("head", `ADDR_BULK_HEAD, 32'h0000_0AB0);
    w(`ADDR_BULK_HEAD, 32'h0000_010F);
    r("head", `ADDR_BULK_HEAD, 32'h0000_0100);
    w(`ADDR_BULK_CURRENT, 32'h0000_0200);
    w(`ADDR_BULK_CTRL, 32'h1);
    w(`ADDR_BULK_CURRENT, 32'h0000_0300);
    r("cur", `ADDR_BULK_CURRENT, 32'h0000_0200);
    chk("en", {31'h0, bulk_enable_o}, 32'h1);
    frame_start_i <= 1'h1;
    @(posedge core_clk_i) frame_start_i <= 1'h0;
    cyc(2);
    chk("act", {31'h0, bulk_active_o}, 32'h1);
    r("cur", `ADDR_BULK_CURRENT, 32'h0000_0200);
    for (int i = 1; i < 4; i++)
    begin
      ed_done_i <= 1'h1;
      @(posedge core_clk_i) ed_done_i <= 1'h0;
      cyc(2);
      chk("walk", bulk_current_o, i < 3 ? 32'h200 + 32'h10 * i : 32'h0);
    end
    list_filled_set_i <= 1'h1;
    @(posedge core_clk_i) list_filled_set_i <= 1'h0;
    cyc(2);
    r("cur", `ADDR_BULK_CURRENT, 32'h0000_0100);
    r("ctl", `ADDR_BULK_CTRL, 32'h1);
    td(32'h0000_0405);
    td(32'h0000_0500);
    chk("lnk", mem_u.mem_q[4], 32'h0);
    chk("lnk", mem_u.mem_q[5], 32'h0000_0400);
    r("done", `ADDR_DONE_HEAD, 32'h0000_0500);
    w(`ADDR_IRQ_ENABLE, 32'h1);
    done_writeback_i <= 1'h1;
    td_done_i <= 1'h1;
    @(posedge core_clk_i) done_writeback_i <= 1'h0;
    td_done_i <= 1'h0;
    cyc(3);
    chk("irq", {31'h0, irq_o}, 32'h1);
    r("done", `ADDR_DONE_HEAD, 32'h0);
    r("sts", `ADDR_IRQ_STATUS, 32'h3);
    w(`ADDR_IRQ_CLEAR, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h0);
    r("sts", `ADDR_IRQ_STATUS, 32'h2);
    r("map", 32'h3000_2C90, 32'h0);
    stop_test();
  end
endmodule : usb_host_bulk_done_list_pointers_tb
